// ==== hw/adc_autoscan_sequencer.sv ====
// =============================================================================
// How it works
// - enabled scan converts each selected input unaided
// - one channel every 10.04 microseconds (502 clocks), pipelined
// - result lands in its channel's own slot
// - channel count selectable as 24, 16, 8
// - each channel sampled, converted, stored as 16 bits
// - host reads any slot anytime, scan undisturbed
// - any reset runs 41 ms self-calibration
// - any reset clears whole control word
// - scanning stays off until enable set
// - disabled scan leaves result memory untouched
// - control word bit triggers software reset
// - control word bit drives fault lamp
// - control word selects result number format
// - sample-and-hold goes to hold before converting
// - mux advances to next input during conversion
// - previous result written during next conversion
// - 32 result words plus one control word
// - results at even indices 0x10 to 0x4e
// - only lowest 24 words receive results
// - 2.0 us sample, then 17 converter clocks
// =============================================================================
`timescale 1ns/100ps

module adc_autoscan_sequencer #(
    parameter int unsigned CAL_CYCLES = adc_autoscan_pkg::CAL_CYCLES
) (
    // clock, reset, clock enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // converter and multiplexer pins
    input  wire logic [15:0] adc_data,
    output logic             adc_sample,
    output logic             adc_clk,
    output logic             adc_cal_busy,
    output logic      [4:0]  mux_channel,
    // board indicator
    output logic             fault_indicator_lamp
);

    // =========================================================================
    // declarations
    // =========================================================================
    localparam int unsigned CW = $clog2(CAL_CYCLES + 1);
    localparam logic [8:0]  SLOT_LAST  = 9'(adc_autoscan_pkg::SLOT_CYCLES - 1);
    localparam logic [8:0]  SAMPLE_END = 9'(adc_autoscan_pkg::SAMPLE_CYCLES);
    localparam logic [8:0]  CONV_END   = 9'(adc_autoscan_pkg::SAMPLE_CYCLES
                                   + 2 * adc_autoscan_pkg::CONV_PULSES
                                   * adc_autoscan_pkg::CONV_HALF_CYCLES);
    localparam logic [8:0]  HALF       = 9'(adc_autoscan_pkg::CONV_HALF_CYCLES);

    adc_autoscan_pkg::ctrl_word_t ctrl_word;     // control part of the word
    adc_autoscan_pkg::seq_state_t state;         // sequencer state
    logic [CW-1:0]                cal_cnt;       // calibration countdown
    logic [8:0]                   slot_cnt;      // position in channel slot
    logic [4:0]                   ch_cur;        // channel being converted
    logic [4:0]                   prev_ch;       // channel awaiting write
    logic                         prev_valid;    // a result awaits write
    logic [15:0]                  data_meta;     // first sync stage
    logic [15:0]                  data_sync;     // second sync stage
    logic [15:0]                  result [adc_autoscan_pkg::RESULT_WORDS];
    logic                         setup;         // apb setup phase
    logic                         wr_done;       // apb write completes
    logic                         soft_reset;    // software reset request
    logic                         scan_write;    // sequencer writes a result
    logic                         scanning;      // state is scan
    logic [8:0]                   conv_phase;    // cycles since hold began

    // =========================================================================
    // helpers
    // =========================================================================
    // channels per scan for a count select
    function automatic logic [4:0] chan_limit(input logic [1:0] sel);
        case (sel)
            2'b00:   chan_limit = adc_autoscan_pkg::CHANNELS_24;
            2'b01:   chan_limit = adc_autoscan_pkg::CHANNELS_16;
            default: chan_limit = adc_autoscan_pkg::CHANNELS_8;
        endcase
    endfunction

    // next channel with wrap to zero
    function automatic logic [4:0] next_chan(input logic [4:0] ch, input logic [1:0] sel);
        next_chan = (5'(ch + 5'h01) >= chan_limit(sel)) ? 5'h00 : 5'(ch + 5'h01);
    endfunction

    // result word hit for a byte address
    function automatic logic result_hit(input logic [11:0] a);
        result_hit = (a >= (adc_autoscan_pkg::RESULT_FIRST_IDX << 2))
                  && (a <= (adc_autoscan_pkg::RESULT_LAST_IDX << 2))
                  && (a[2:0] == 3'h0);
    endfunction

    // result word number for a byte address
    function automatic logic [4:0] result_num(input logic [11:0] a);
        logic [11:0] off;
        off        = 12'(a - (adc_autoscan_pkg::RESULT_FIRST_IDX << 2));
        result_num = off[7:3];
    endfunction

    assign setup      = psel && !penable;
    assign wr_done    = psel && penable && pready && pwrite;
    assign soft_reset = ce && wr_done && (paddr == (adc_autoscan_pkg::CTRL_WORD_INDEX << 2))
                        && pwdata[adc_autoscan_pkg::SOFT_RESET_BIT];
    assign scanning   = (state == adc_autoscan_pkg::ST_SCAN);
    assign conv_phase = 9'(slot_cnt - SAMPLE_END);
    // write of the previous result while this channel converts
    assign scan_write = ce && scanning && ctrl_word.scan_enable
                        && (slot_cnt == SAMPLE_END) && prev_valid;

    // =========================================================================
    // control word
    // =========================================================================
    // software writes, cleared on any reset including its own reset bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_word <= adc_autoscan_pkg::CTRL_WORD_RESET;
        else if (ce)
        begin
            if (soft_reset)
                ctrl_word <= adc_autoscan_pkg::CTRL_WORD_RESET;
            else if (wr_done && paddr == (adc_autoscan_pkg::CTRL_WORD_INDEX << 2))
                ctrl_word <= adc_autoscan_pkg::ctrl_word_t'(pwdata[4:0]);
        end
    end

    // =========================================================================
    // converter data synchroniser
    // =========================================================================
    // latched converter word comes from off-chip pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_meta <= 16'h0000;
            data_sync <= 16'h0000;
        end
        else if (ce)
        begin
            data_meta <= adc_data;
            data_sync <= data_meta;
        end
    end

    // =========================================================================
    // sequencer state
    // =========================================================================
    // calibration, idle and scan; soft reset restarts calibration
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state   <= adc_autoscan_pkg::ST_CAL;
            cal_cnt <= CW'(CAL_CYCLES);
        end
        else if (ce)
        begin
            if (soft_reset)
            begin
                state   <= adc_autoscan_pkg::ST_CAL;
                cal_cnt <= CW'(CAL_CYCLES);
            end
            else
            begin
                case (state)
                    // hold off all scanning until calibration ends
                    adc_autoscan_pkg::ST_CAL:
                    begin
                        if (cal_cnt <= CW'(1))
                            state <= adc_autoscan_pkg::ST_IDLE;
                        else
                            cal_cnt <= CW'(cal_cnt - CW'(1));
                    end
                    // wait for enable
                    adc_autoscan_pkg::ST_IDLE:
                    begin
                        if (ctrl_word.scan_enable)
                            state <= adc_autoscan_pkg::ST_SCAN;
                    end
                    // stop at the end of a slot once disabled
                    adc_autoscan_pkg::ST_SCAN:
                    begin
                        if (!ctrl_word.scan_enable && slot_cnt == SLOT_LAST)
                            state <= adc_autoscan_pkg::ST_IDLE;
                    end
                    default:
                        state <= adc_autoscan_pkg::ST_CAL;
                endcase
            end
        end
    end

    // =========================================================================
    // slot timing and channel pipeline
    // =========================================================================
    // slot counter, mux advance at hold, pending result bookkeeping
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slot_cnt    <= 9'h000;
            ch_cur      <= 5'h00;
            prev_ch     <= 5'h00;
            prev_valid  <= 1'b0;
            mux_channel <= 5'h00;
        end
        else if (ce)
        begin
            if (!scanning || soft_reset)
            begin
                // restart from channel zero on the next scan
                slot_cnt    <= 9'h000;
                ch_cur      <= 5'h00;
                prev_valid  <= 1'b0;
                mux_channel <= 5'h00;
            end
            else
            begin
                slot_cnt <= (slot_cnt == SLOT_LAST) ? 9'h000 : 9'(slot_cnt + 9'h001);
                if (slot_cnt == SAMPLE_END)
                begin
                    // settle the next input while this one converts
                    mux_channel <= next_chan(ch_cur, ctrl_word.channel_count_select);
                    prev_ch     <= ch_cur;
                    prev_valid  <= 1'b1;
                end
                if (slot_cnt == SLOT_LAST)
                    ch_cur <= mux_channel;
            end
        end
    end

    // =========================================================================
    // converter pins
    // =========================================================================
    // sample command for the first 2 us, then 17 clock pulses in hold
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adc_sample   <= 1'b0;
            adc_clk      <= 1'b0;
            adc_cal_busy <= 1'b1;
        end
        else if (ce)
        begin
            adc_cal_busy <= (state == adc_autoscan_pkg::ST_CAL) || soft_reset;
            adc_sample   <= scanning && (slot_cnt < SAMPLE_END);
            // even half periods high, odd ones low: 17 whole pulses
            adc_clk      <= scanning && (slot_cnt >= SAMPLE_END) && (slot_cnt < CONV_END)
                            && ((conv_phase / HALF) % 9'h002 == 9'h000);
        end
    end

    // =========================================================================
    // result memory with arbitration
    // =========================================================================
    // sequencer write on its fixed cycle; host write to another word same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < adc_autoscan_pkg::RESULT_WORDS; i++)
                result[i] <= 16'h0000;
        end
        else if (ce)
        begin
            if (wr_done && result_hit(paddr))
                result[result_num(paddr)] <= pwdata[15:0];
            if (scan_write)
                result[prev_ch] <= data_sync;
        end
    end

    // =========================================================================
    // apb answer
    // =========================================================================
    // one wait-free access phase: data prepared during setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready  <= setup;
            pslverr <= setup && !result_hit(paddr)
                       && (paddr != (adc_autoscan_pkg::CTRL_WORD_INDEX << 2));
            if (!setup || pwrite)
                prdata <= 32'h0000_0000;
            else if (paddr == (adc_autoscan_pkg::CTRL_WORD_INDEX << 2))
                prdata <= {22'h000000, scanning, state == adc_autoscan_pkg::ST_CAL,
                           3'h0, ctrl_word};
            else if (result_hit(paddr) && result_num(paddr) < adc_autoscan_pkg::CHANNELS_24
                     && ctrl_word.twos_complement)
                prdata <= {16'h0000, ~result[result_num(paddr)][15],
                           result[result_num(paddr)][14:0]};
            else if (result_hit(paddr))
                prdata <= {16'h0000, result[result_num(paddr)]};
            else
                prdata <= 32'h0000_0000;
        end
    end

    // lamp follows the control word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fault_indicator_lamp <= 1'b0;
        else if (ce)
            fault_indicator_lamp <= ctrl_word.fault_indicator_lamp;
    end

    // =========================================================================
    // assertions
    // =========================================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        ce && psel && !penable;
    endsequence
    sequence s_answer;
        pready;
    endsequence

    a_apb_answer_next: assert property (s_setup |=> s_answer)
        else $error("apb access not answered in one cycle");
    a_soft_reset_clears: assert property (soft_reset |=> ctrl_word == '0 && adc_cal_busy)
        else $error("soft reset did not clear control word");
    a_cal_no_scan: assert property (ce && state == adc_autoscan_pkg::ST_CAL |-> !scan_write
                                    ##1 (!adc_sample && !adc_clk))
        else $error("scan activity during calibration");
    a_idle_no_write: assert property (!ctrl_word.scan_enable |-> !scan_write)
        else $error("result written while scan disabled");
    a_hold_before_clock: assert property ($rose(adc_clk) |-> !adc_sample)
        else $error("converter clocked while sampling");
    a_mux_next_chan: assert property (ce && scanning && slot_cnt == SAMPLE_END
        && !soft_reset |=> mux_channel == next_chan(prev_ch, ctrl_word.channel_count_select)
        && mux_channel < chan_limit(ctrl_word.channel_count_select))
        else $error("mux did not advance to next channel");
    a_write_low_slot: assert property (scan_write |-> prev_ch < adc_autoscan_pkg::CHANNELS_24
                                       ##1 result[$past(prev_ch)] == $past(data_sync))
        else $error("result written to wrong slot");
    a_slot_wraps: assert property (ce && scanning && slot_cnt == SLOT_LAST && !soft_reset
                                   |=> slot_cnt == 9'h000)
        else $error("slot length wrong");
    a_sample_ends: assert property (ce && scanning && slot_cnt == SAMPLE_END
                                    |=> !adc_sample)
        else $error("sample command too long");

endmodule // adc_autoscan_sequencer

// ==== hw/adc_autoscan_pkg.sv ====
// =============================================================================
// shared constants and types for the autoscan sequencer
// =============================================================================
package adc_autoscan_pkg;

    // clock period of pclk in ns
    localparam int unsigned CLK_PERIOD_NS    = 20;

    // channel slot, sample command and self-calibration times
    localparam int unsigned SLOT_TIME_NS     = 10050;
    localparam int unsigned SAMPLE_TIME_NS   = 2000;
    localparam int unsigned CAL_TIME_MS      = 41;

    // derived cycle counts (slot rounds down, sample rounds up)
    localparam int unsigned SLOT_CYCLES      = SLOT_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned SAMPLE_CYCLES    = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS;
    localparam int unsigned CAL_CYCLES       = (CAL_TIME_MS * 1000000) / CLK_PERIOD_NS;

    // converter clock: pulses per conversion and half period in pclk cycles
    localparam int unsigned CONV_PULSES      = 17;
    localparam int unsigned CONV_HALF_CYCLES = 10;

    // channel counts per scan
    localparam logic [4:0]  CHANNELS_24      = 5'h18;
    localparam logic [4:0]  CHANNELS_16      = 5'h10;
    localparam logic [4:0]  CHANNELS_8       = 5'h08;
    localparam int unsigned RESULT_WORDS     = 32;

    // register indices; byte address is four times the index
    localparam logic [11:0] CTRL_WORD_INDEX  = 12'h000;
    localparam logic [11:0] RESULT_FIRST_IDX = 12'h010;
    localparam logic [11:0] RESULT_LAST_IDX  = 12'h04e;

    // control/status word bit positions
    localparam int unsigned SOFT_RESET_BIT   = 5;
    localparam int unsigned CAL_BUSY_BIT     = 8;
    localparam int unsigned SCAN_ACTIVE_BIT  = 9;

    // control part of the control/status word, cleared by every reset
    typedef struct packed {
        logic       fault_indicator_lamp;  // bit 4
        logic       twos_complement;       // bit 3: result format
        logic [1:0] channel_count_select;  // bits 2:1: 00=24 01=16 1x=8
        logic       scan_enable;           // bit 0
    } ctrl_word_t;

    localparam ctrl_word_t CTRL_WORD_RESET = '0;

    // sequencer states
    typedef enum logic [1:0] {ST_CAL, ST_IDLE, ST_SCAN} seq_state_t;

endpackage

// ==== tb/adc_converter_model.sv ====
`timescale 1ns/100ps
// =============================================================================
// converter model: holds the channel taken at sample start, answers after 17
// =============================================================================
module adc_converter_model (
    // pins from the sequencer
    input  wire logic        adc_sample,
    input  wire logic        adc_clk,
    input  wire logic [4:0]  mux_channel,
    // output latch
    output logic      [15:0] adc_data,
    // conversions that saw more than 17 clocks
    output int               pulse_faults
);
    logic [4:0] held_ch;  // channel under conversion
    int         pulses;   // converter clocks seen

    initial
    begin
        adc_data = 16'h0000;
        pulses   = 0;
        pulse_faults = 0;
    end

    // sample command start: take channel, flag excess clocks, restart count
    always @(posedge adc_sample)
    begin
        if (pulses > 17)
            pulse_faults = pulse_faults + 1;
        held_ch = mux_channel;
        pulses  = 0;
    end

    // latch updates after the 17th rising edge only
    always @(posedge adc_clk)
    begin
        pulses = pulses + 1;
        if (pulses == 17)
        begin
            adc_data <= 16'h8a00 + {11'h000, held_ch};
        end
    end
endmodule // adc_converter_model

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
// =============================================================================
// testbench: apb host driving the sequencer
// =============================================================================
module testbench;
    localparam int SLOT = adc_autoscan_pkg::SLOT_CYCLES;  // cycles per channel slot

    // clock, reset, apb
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    // converter side
    logic [15:0] adc_data;
    logic        adc_sample;
    logic        adc_clk;
    logic        adc_cal_busy;
    logic [4:0]  mux_channel;
    logic        fault_indicator_lamp;
    // bookkeeping
    int          err_total;
    int          comparisons;
    logic [31:0] rdata;
    logic        last_err;
    int          pulse_faults;
    logic [1:0]  codes [3];
    int          counts [3];

    adc_autoscan_sequencer #(.CAL_CYCLES(20)) dut_u (
        .pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_data(adc_data), .adc_sample(adc_sample), .adc_clk(adc_clk),
        .adc_cal_busy(adc_cal_busy), .mux_channel(mux_channel),
        .fault_indicator_lamp(fault_indicator_lamp)
    );

    adc_converter_model conv_u (
        .adc_sample(adc_sample), .adc_clk(adc_clk),
        .mux_channel(mux_channel), .adc_data(adc_data),
        .pulse_faults(pulse_faults)
    );

    // clock generator
    always #10 pclk = ~pclk;

    // byte address of result word i
    function automatic logic [11:0] word(input int i);
        return 12'h040 + 12'(8 * i);
    endfunction

    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    begin
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // only the watchdog ends a wait that never sees pready
        while (pready !== 1'b1)
            @(posedge pclk);
        rdata    = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    end
    endtask

    // verdict and end of run
    task automatic final_report();
    begin
        if (err_total == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask

    // main sequence
    initial
    begin
        pclk        = 1'b0;
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 12'h000;
        pwdata      = 32'h0000_0000;
        err_total   = 0;
        comparisons = 0;
        codes       = '{2'b10, 2'b01, 2'b00};
        counts      = '{8, 16, 24};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        check(rdata, 32'h0000_0100);
        check({31'h0, adc_cal_busy}, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        check({31'h0, last_err}, 32'h1);
        apb(1'b1, word(31), 32'h1234);
        for (int m = 0; m < 3; m++)
        begin
            // calibration over, everything still off
            repeat (40) @(posedge pclk);
            check({31'h0, adc_cal_busy}, 32'h0);
            apb(1'b0, 12'h000, 32'h0);
            check(rdata, 32'h0);
            for (int k = 0; k < 31; k++)
                apb(1'b1, word(k), 32'h5555);
            apb(1'b0, word(0), 32'h0);
            check(rdata, 32'h5555);
            // lamp on, channel count, enable
            apb(1'b1, 12'h000, {27'h0, 1'b1, 1'b0, codes[m], 1'b1});
            // lamp flop follows the word one edge later
            @(posedge pclk);
            @(negedge pclk);
            check({31'h0, fault_indicator_lamp}, 32'h1);
            apb(1'b0, 12'h000, 32'h0);
            check(rdata, {22'h0, 1'b1, 5'h01, 1'b0, codes[m], 1'b1});
            repeat ((counts[m] + 1) * SLOT + 20) @(posedge pclk);
            // results in own slots, rest untouched
            for (int k = 0; k < 31; k++)
            begin
                apb(1'b0, word(k), 32'h0);
                check(rdata, (k < counts[m]) ? 32'(32'h8a00 + k) : 32'h5555);
            end
            // two's complement view inverts the top bit
            apb(1'b1, 12'h000, {27'h0, 1'b1, 1'b1, codes[m], 1'b1});
            apb(1'b0, word(1), 32'h0);
            check(rdata, 32'h0a01);
            // software reset clears word and restarts calibration
            apb(1'b1, 12'h000, 32'h20);
            @(posedge pclk);
            @(negedge pclk);
            check({31'h0, fault_indicator_lamp}, 32'h0);
            check({31'h0, adc_cal_busy}, 32'h1);
            apb(1'b0, 12'h000, 32'h0);
            check(rdata & 32'hffff_fdff, 32'h0000_0100);
        end
        check(32'(pulse_faults), 32'h0);
        apb(1'b0, word(31), 32'h0);
        check(rdata, 32'h1234);
        final_report();
    end

    // watchdog against a hang
    initial
    begin
        repeat (60000) @(posedge pclk);
        err_total++;
        final_report();
    end
endmodule // testbench
